/* File: rtl/rms_mode_strap.sv */
/*
 * Reset-time mode strap selector: latches the operating mode, runs the emulated
 * transceiver register link with its active-low interrupt, and drives the
 * RF-field-on test stream. Assumes all pins are synchronous to clock and that
 * the interrupt strap pin is resolved outside from irq_pin_out and irq_pin_oe_n.
 */
`timescale 1ns/10ps
`default_nettype none
`include "rms_map.svh"
module rms_mode_strap #(
    parameter logic [15:0] UART_BIT_CYC = 16'(`RMS_CLK_HZ / `RMS_UART_BAUD),
    parameter logic [15:0] BYTE_CYC_106 =
        16'((`RMS_CLK_HZ / 1000) * `RMS_BITS_PER_BYTE / `RMS_RATE_106_KBPS),
    parameter logic [15:0] BYTE_CYC_212 =
        16'((`RMS_CLK_HZ / 1000) * `RMS_BITS_PER_BYTE / `RMS_RATE_212_KBPS),
    parameter logic [15:0] BYTE_CYC_424 =
        16'((`RMS_CLK_HZ / 1000) * `RMS_BITS_PER_BYTE / `RMS_RATE_424_KBPS)
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // mode straps; the interrupt strap doubles as the interrupt output
    input  wire logic       mode_strap_irq_pin_in,
    output logic            mode_strap_irq_pin_out,
    output logic            mode_strap_irq_pin_oe_n,
    input  wire logic       mode_strap_second_pin,
    // carrier test selection pins
    input  wire logic       tx_select_first_pin,
    input  wire logic       tx_select_second_pin,
    // emulation serial link
    input  wire logic       uart_rxd,
    output logic            uart_txd,
    // emulated interrupt sources, one-cycle pulses
    input  wire logic [6:0] irq_event,
    // mode status
    output rms_pkg::rms_mode_t mode,
    output logic            temp_sensor_en,
    // rf front end
    output logic            rf_carrier_on,
    output rms_pkg::rms_frm_t rf_framing,
    output logic            rf_byte_valid,
    output logic [7:0]      rf_byte
);
    typedef struct packed {
        logic                 captured;
        rms_pkg::rms_mode_t   mode;
        rms_pkg::rms_frm_t    frm;
        logic                 irq_out;
        logic                 irq_oe_n;
        logic                 temp_en;
        logic                 rf_on;
        logic [15:0]          byte_cnt;
        logic [15:0]          lfsr;
        logic [7:0]           rf_byte;
        logic                 rf_valid;
        rms_pkg::rms_proto_t  proto;
        logic [5:0]           addr;
        logic                 tx_start;
        logic [7:0]           tx_data;
        logic [6:0]           irq_req;
        logic [7:0]           irq_en;
        logic [63:0][7:0]     regs;
    } rms_core_t;

    rms_core_t st_r, st_nxt;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_busy;
    logic [15:0] byte_cyc;

    // ------------------------------------------------------------------------
    // serial port at the fixed emulation rate
    // ------------------------------------------------------------------------
    rms_uart #(.BIT_CYC(UART_BIT_CYC)) u_uart (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .rxd      (uart_rxd),
        .txd      (uart_txd),
        .rx_valid (rx_valid),
        .rx_data  (rx_data),
        .tx_start (st_r.tx_start),
        .tx_data  (st_r.tx_data),
        .tx_busy  (tx_busy)
    );

    // byte period for the latched carrier framing
    always_comb begin
        unique case (st_r.frm)
            rms_pkg::FRM_C212: byte_cyc = BYTE_CYC_212;
            rms_pkg::FRM_C424: byte_cyc = BYTE_CYC_424;
            default:           byte_cyc = BYTE_CYC_106; // covers the unset code
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.tx_start = 1'b0;
        st_nxt.rf_valid = 1'b0;
        // straps are taken on the first edge after release and never again
        if (!st_r.captured) begin
            st_nxt.captured = 1'b1;
            if (mode_strap_irq_pin_in && !mode_strap_second_pin) begin
                st_nxt.mode = rms_pkg::MODE_EMU;
            end else if (!mode_strap_irq_pin_in && mode_strap_second_pin) begin
                st_nxt.mode = rms_pkg::MODE_RFON;
            end else begin
                st_nxt.mode = rms_pkg::MODE_STD;
            end
            unique case ({tx_select_first_pin, tx_select_second_pin})
                2'b01:   st_nxt.frm = rms_pkg::FRM_C212;
                2'b10:   st_nxt.frm = rms_pkg::FRM_C424;
                default: st_nxt.frm = rms_pkg::FRM_A106;
            endcase
        end
        // lfsr free-runs; sampling it at byte time gives pseudo-random data
        st_nxt.lfsr = {st_r.lfsr[14:0],
                       st_r.lfsr[15] ^ st_r.lfsr[13] ^ st_r.lfsr[12] ^ st_r.lfsr[10]};
        st_nxt.rf_on = (st_nxt.mode == rms_pkg::MODE_RFON);
        st_nxt.temp_en = st_nxt.captured && (st_nxt.mode != rms_pkg::MODE_RFON);
        // continuous random stream in carrier test mode
        if (st_r.mode == rms_pkg::MODE_RFON) begin
            if (st_r.byte_cnt == 16'h0000) begin
                st_nxt.byte_cnt = byte_cyc - 16'h0001;
                st_nxt.rf_valid = 1'b1;
                st_nxt.rf_byte = st_r.lfsr[7:0];
            end else begin
                st_nxt.byte_cnt = st_r.byte_cnt - 16'h0001;
            end
        end
        // emulated register link: address byte, then data byte or reply
        if (st_r.mode == rms_pkg::MODE_EMU) begin
            unique case (st_r.proto)
                rms_pkg::PR_ADDR: begin
                    if (rx_valid) begin
                        st_nxt.addr = rx_data[`RMS_ADDR_MSB:`RMS_ADDR_LSB];
                        if (rx_data[`RMS_RD_BIT]) begin
                            st_nxt.proto = rms_pkg::PR_RSEND;
                            st_nxt.tx_start = 1'b1;
                            unique case (rx_data[`RMS_ADDR_MSB:`RMS_ADDR_LSB])
                                `RMS_REG_COMM_IEN:    st_nxt.tx_data = st_r.irq_en;
                                `RMS_REG_COMM_IRQ:    st_nxt.tx_data = {1'b0, st_r.irq_req};
                                `RMS_REG_SERIAL_BAUD: st_nxt.tx_data = `RMS_BYTE_ZERO;
                                default: st_nxt.tx_data =
                                    st_r.regs[rx_data[`RMS_ADDR_MSB:`RMS_ADDR_LSB]];
                            endcase
                        end else begin
                            st_nxt.proto = rms_pkg::PR_WDATA;
                        end
                    end
                end
                rms_pkg::PR_WDATA: begin
                    if (rx_valid) begin
                        st_nxt.proto = rms_pkg::PR_ADDR;
                        unique case (st_r.addr)
                            `RMS_REG_COMM_IEN: st_nxt.irq_en = rx_data;
                            `RMS_REG_COMM_IRQ: begin
                                // top bit chooses set or clear of the marked bits
                                if (rx_data[`RMS_IRQ_SET_BIT]) begin
                                    st_nxt.irq_req = st_r.irq_req | rx_data[6:0];
                                end else begin
                                    st_nxt.irq_req = st_r.irq_req & ~rx_data[6:0];
                                end
                            end
                            `RMS_REG_SERIAL_BAUD: ; // not emulated: rate stays fixed
                            default: st_nxt.regs[st_r.addr] = rx_data;
                        endcase
                    end
                end
                rms_pkg::PR_RSEND: begin
                    if (!tx_busy && !st_r.tx_start) begin
                        st_nxt.proto = rms_pkg::PR_ADDR;
                    end
                end
            endcase
            // a source event wins over a clear in the same cycle
            st_nxt.irq_req = st_nxt.irq_req | irq_event;
        end
        // active low, polarity bit deliberately left out of the term
        st_nxt.irq_oe_n = !(st_nxt.mode == rms_pkg::MODE_EMU);
        st_nxt.irq_out = ~|(st_nxt.irq_req & st_nxt.irq_en[6:0]);
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.mode <= rms_pkg::MODE_STD;
            st_r.frm <= rms_pkg::FRM_A106;
            st_r.proto <= rms_pkg::PR_ADDR;
            st_r.irq_out <= 1'b1;
            st_r.irq_oe_n <= 1'b1;
            st_r.lfsr <= `RMS_LFSR_SEED;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mode_strap_irq_pin_out = st_r.irq_out;
    assign mode_strap_irq_pin_oe_n = st_r.irq_oe_n;
    assign mode = st_r.mode;
    assign temp_sensor_en = st_r.temp_en;
    assign rf_carrier_on = st_r.rf_on;
    assign rf_framing = st_r.frm;
    assign rf_byte_valid = st_r.rf_valid;
    assign rf_byte = st_r.rf_byte;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence s_capture;
        !st_r.captured ##1 st_r.captured;
    endsequence
    sequence s_read_req;
        st_r.mode == rms_pkg::MODE_EMU && st_r.proto == rms_pkg::PR_ADDR
            && rx_valid && rx_data[`RMS_RD_BIT];
    endsequence

    mode_held_a: assert property (st_r.captured |=> $stable(st_r.mode))
        else $error("mode changed after capture");
    std_default_a: assert property (!st_r.captured
        && (mode_strap_irq_pin_in == mode_strap_second_pin)
        |=> st_r.mode == rms_pkg::MODE_STD)
        else $error("equal straps did not give standard mode");
    emu_select_a: assert property (!st_r.captured && mode_strap_irq_pin_in
        && !mode_strap_second_pin |=> st_r.mode == rms_pkg::MODE_EMU)
        else $error("emulation straps not honoured");
    carrier_on_a: assert property (s_capture ##0 (st_r.mode == rms_pkg::MODE_RFON)
        |=> rf_carrier_on)
        else $error("carrier not on after reset in field mode");
    temp_off_a: assert property (st_r.mode == rms_pkg::MODE_RFON |=> !temp_sensor_en)
        else $error("temperature sensor on in field mode");
    read_reply_a: assert property (s_read_req |=> st_r.tx_start ##1 tx_busy)
        else $error("register read got no reply");
    irq_level_a: assert property (st_r.mode == rms_pkg::MODE_EMU && !rx_valid
        && |(irq_event & st_r.irq_en[6:0]) |=> !mode_strap_irq_pin_out)
        else $error("interrupt line not low for an enabled pending source");
    irq_drive_a: assert property (st_r.captured |-> (mode_strap_irq_pin_oe_n
        == (st_r.mode != rms_pkg::MODE_EMU)))
        else $error("interrupt pin drive wrong for mode");
    stream_gap_a: assert property (rf_byte_valid |=> !rf_byte_valid [*8])
        else $error("carrier bytes closer than their period");
endmodule
`default_nettype wire

/* File: rtl/rms_uart.sv */
/*
 * Fixed-rate 8N1 UART, transmit and receive, for the emulation link.
 * Assumes rxd is already synchronous to clock; the bit period is a fixed parameter.
 */
`timescale 1ns/10ps
`default_nettype none
module rms_uart #(
    parameter logic [15:0] BIT_CYC = 16'h32DC
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // serial pins
    input  wire logic       rxd,
    output logic            txd,
    // receive side
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    // transmit side
    input  wire logic       tx_start,
    input  wire logic [7:0] tx_data,
    output logic            tx_busy
);
    typedef struct packed {
        logic        txd;
        logic        tx_busy;
        logic [9:0]  tx_sh;
        logic [3:0]  tx_n;
        logic [15:0] tx_cnt;
        logic        rx_busy;
        logic [3:0]  rx_n;
        logic [15:0] rx_cnt;
        logic [7:0]  rx_sh;
        logic        rx_valid;
        logic [7:0]  rx_data;
    } rms_uart_st_t;

    rms_uart_st_t st_r, st_nxt;

    // ------------------------------------------------------------------------
    // bit timing: the period never comes from a register, so it cannot drift
    // ------------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.rx_valid = 1'b0;
        // transmit: start, 8 data lsb first, stop
        if (!st_r.tx_busy) begin
            if (tx_start) begin
                st_nxt.tx_busy = 1'b1;
                st_nxt.tx_sh = {1'b1, tx_data, 1'b0};
                st_nxt.tx_n = 4'h0;
                st_nxt.tx_cnt = BIT_CYC - 16'h0001;
                st_nxt.txd = 1'b0;
            end
        end else if (st_r.tx_cnt == 16'h0000) begin
            if (st_r.tx_n == 4'h9) begin
                st_nxt.tx_busy = 1'b0;
                st_nxt.txd = 1'b1;
            end else begin
                st_nxt.tx_sh = {1'b1, st_r.tx_sh[9:1]};
                st_nxt.txd = st_r.tx_sh[1];
                st_nxt.tx_n = st_r.tx_n + 4'h1;
                st_nxt.tx_cnt = BIT_CYC - 16'h0001;
            end
        end else begin
            st_nxt.tx_cnt = st_r.tx_cnt - 16'h0001;
        end
        // receive: sample each bit in its middle
        if (!st_r.rx_busy) begin
            if (!rxd) begin
                st_nxt.rx_busy = 1'b1;
                st_nxt.rx_n = 4'h0;
                st_nxt.rx_cnt = {1'b0, BIT_CYC[15:1]};
            end
        end else if (st_r.rx_cnt == 16'h0000) begin
            st_nxt.rx_cnt = BIT_CYC - 16'h0001;
            st_nxt.rx_n = st_r.rx_n + 4'h1;
            if (st_r.rx_n == 4'h0) begin
                st_nxt.rx_busy = !rxd; // glitch on start bit aborts
            end else if (st_r.rx_n == 4'h9) begin
                st_nxt.rx_busy = 1'b0;
                st_nxt.rx_valid = rxd; // bad stop bit drops the byte
                st_nxt.rx_data = st_r.rx_sh;
            end else begin
                st_nxt.rx_sh = {rxd, st_r.rx_sh[7:1]};
            end
        end else begin
            st_nxt.rx_cnt = st_r.rx_cnt - 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.txd <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign txd = st_r.txd;
    assign tx_busy = st_r.tx_busy;
    assign rx_valid = st_r.rx_valid;
    assign rx_data = st_r.rx_data;

    // a started frame holds its start bit low for at least 8 cycles
    uart_period_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(st_r.txd) |-> (st_r.txd == 1'b0) [*8])
        else $error("tx start bit shorter than expected");
endmodule
`default_nettype wire

/* File: shared/rms_map.svh */
/*
 * Named constants for the reset-time mode strap selector: reset values, emulated
 * register addresses, field positions, serial and carrier timing figures.
 * Assumes it is included by its bare name from package and design files.
 */
// Summary of operation
// - Two straps sampled at reset pick one of three modes.
// - Equal strap levels, or any other case, select standard mode.
// - Emulation mode answers emulated transceiver register accesses over the serial link.
// - Emulation serial link is a plain UART fixed at 9600 baud.
// - Writes to the emulated serial speed register never change the link rate.
// - In emulation the interrupt strap pin becomes the interrupt output.
// - Emulated interrupt line is low while an enabled interrupt is pending, else high.
// - Interrupt polarity-inversion bit is ignored; output stays active low.
// - RF-field-on mode turns the carrier on as soon as reset ends.
// - RF-field-on sends random bytes; two pins pick framing and bit rate.
// - RF-field-on mode keeps the temperature sensor disabled.
`ifndef RMS_MAP_SVH
`define RMS_MAP_SVH

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define RMS_CLK_HZ          125000000
`define RMS_UART_BAUD       9600
`define RMS_RATE_106_KBPS   106
`define RMS_RATE_212_KBPS   212
`define RMS_RATE_424_KBPS   424
`define RMS_BITS_PER_BYTE   8

// ----------------------------------------------------------------------------
// emulated register map (6-bit address) and fields
// ----------------------------------------------------------------------------
`define RMS_REG_COMM_IEN    6'h02
`define RMS_REG_COMM_IRQ    6'h04
`define RMS_REG_SERIAL_BAUD 6'h1F
`define RMS_IRQ_INV_BIT     7
`define RMS_IRQ_SET_BIT     7
`define RMS_RD_BIT          7
`define RMS_ADDR_MSB        6
`define RMS_ADDR_LSB        1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RMS_LFSR_SEED       16'hACE1
`define RMS_BYTE_ZERO       8'h00

`endif

/* File: shared/rms_pkg.sv */
/*
 * Types shared by the mode strap selector and its testbench.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package rms_pkg;
    // one-hot operating modes
    typedef enum logic [2:0] {
        MODE_STD  = 3'h1,
        MODE_EMU  = 3'h2,
        MODE_RFON = 3'h4
    } rms_mode_t;

    // carrier framing / bit rate choice
    typedef enum logic [2:0] {
        FRM_A106 = 3'h1,
        FRM_C212 = 3'h2,
        FRM_C424 = 3'h4
    } rms_frm_t;

    // serial register protocol
    typedef enum logic [2:0] {
        PR_ADDR  = 3'h1,
        PR_WDATA = 3'h2,
        PR_RSEND = 3'h4
    } rms_proto_t;
endpackage
`default_nettype wire

/* File: testbench/rms_host_model.sv */
/*
 * Host side of the emulation serial link: sends and receives 8N1 frames.
 * Assumes the device line is idle high and all timing is in clock cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module rms_host_model #(
    parameter int BIT_CYC = 16
) (
    // clock
    input  wire logic       clock,
    // serial lines
    input  wire logic       dev_txd,
    output logic            host_txd,
    // received byte, one cycle from falling edge to falling edge
    output logic            got_valid,
    output logic [7:0]      got_byte
);
    initial begin
        host_txd = 1'b1;
        got_valid = 1'b0;
        got_byte = 8'h00;
    end

    // one frame, lsb first, at the only rate the link knows
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            host_txd = f[i];
            repeat (BIT_CYC) @(negedge clock);
        end
    endtask

    // sample mid bit at the fixed rate; a wrong rate garbles the byte
    always begin
        @(negedge dev_txd);
        repeat (BIT_CYC / 2) @(negedge clock);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(negedge clock);
            got_byte[i] = dev_txd;
        end
        repeat (BIT_CYC) @(negedge clock);
        got_valid = dev_txd;   // a low stop bit drops the byte
        @(negedge clock);
        got_valid = 1'b0;
    end
endmodule
`default_nettype wire

/* File: testbench/rms_mode_strap_tb.sv */
/*
 * Self-checking bench for the mode strap selector: strap capture, RF stream
 * spacing, emulated register link and interrupt pin. Assumes shortened counts.
 */
`timescale 1ns/10ps
`default_nettype none
module rms_mode_strap_tb;
    logic               clock = 1'b0;
    logic               sys_rst = 1'b1;
    logic               strap_irq = 1'b1;
    logic               strap_second = 1'b1;
    logic [1:0]         sel = 2'h0;
    logic [6:0]         irq_event = 7'h00;
    wire logic          irq_pin;
    logic               irq_out;
    logic               irq_oe_n;
    logic               rxd;
    logic               txd;
    logic               got_valid;
    logic [7:0]         got_byte;
    rms_pkg::rms_mode_t mode;
    logic               temp_en;
    logic               carrier;
    rms_pkg::rms_frm_t  framing;
    logic               rf_valid;
    logic [7:0]         rf_byte;
    logic [7:0]         exp_q [$];
    logic [31:0]        seed = 32'd94781;
    int                 n_mismatch = 0;
    int                 samples_checked = 0;
    logic [7:0]         rf_last = 8'h00;
    int                 rf_diff = 0;
    logic [15:0]        gaps [4] = '{16'h0014, 16'h000C, 16'h000A, 16'h0014};
    logic [2:0]         frms [4] = '{3'h1, 3'h2, 3'h4, 3'h1};

    // the strap pin level: the device only wins while its enable is low
    assign irq_pin = irq_oe_n ? strap_irq : irq_out;

    initial begin
        forever #4 clock = ~clock;
    end

    rms_mode_strap #(
        .UART_BIT_CYC(16'h0010), .BYTE_CYC_106(16'h0014),
        .BYTE_CYC_212(16'h000C), .BYTE_CYC_424(16'h000A)
    ) rms_mode_strap_i (
        .clock(clock), .sys_rst(sys_rst),
        .mode_strap_irq_pin_in(irq_pin), .mode_strap_irq_pin_out(irq_out),
        .mode_strap_irq_pin_oe_n(irq_oe_n), .mode_strap_second_pin(strap_second),
        .tx_select_first_pin(sel[1]), .tx_select_second_pin(sel[0]),
        .uart_rxd(rxd), .uart_txd(txd), .irq_event(irq_event),
        .mode(mode), .temp_sensor_en(temp_en), .rf_carrier_on(carrier),
        .rf_framing(framing), .rf_byte_valid(rf_valid), .rf_byte(rf_byte)
    );

    rms_host_model #(.BIT_CYC(16)) rms_host_model_i (
        .clock(clock), .dev_txd(txd), .host_txd(rxd),
        .got_valid(got_valid), .got_byte(got_byte)
    );

    // --------------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk_v(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // count falling edges up to the next stream pulse, bounded
    task automatic rf_gap(input logic [15:0] e);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (rf_valid !== 1'b1 && n < 200);
        chk_v("rf byte period", e, 16'(n));
        // a stuck stream would repeat its byte at every pulse
        if (rf_byte !== rf_last) rf_diff++;
        rf_last = rf_byte;
    endtask

    // reset with given straps, then check what the capture produced
    task automatic do_reset(input logic i, input logic s, input logic [1:0] sl);
        logic [2:0] em;
        @(negedge clock);
        sys_rst = 1'b1;
        strap_irq = i;
        strap_second = s;
        sel = sl;
        repeat (5) @(negedge clock);
        sys_rst = 1'b0;
        repeat (2) @(negedge clock);
        em = (i & ~s) ? 3'h2 : ((~i & s) ? 3'h4 : 3'h1);
        chk_v("mode", 16'(em), 16'(mode));
        chk_v("irq enable_n", 16'(em != 3'h2), 16'(irq_oe_n));
        chk_v("carrier", 16'(em == 3'h4), 16'(carrier));
        chk_v("temp sensor", 16'(em != 3'h4), 16'(temp_en));
        if (em == 3'h4) begin
            chk_v("first rf pulse", 16'h0001, 16'(rf_valid));
            chk_v("framing", 16'(frms[sl]), 16'(framing));
            rf_gap(gaps[sl]);
        end
        // later strap activity must not move anything
        strap_second = ~s;
        sel = ~sl;
        repeat (3) @(negedge clock);
        chk_v("held mode", 16'(em), 16'(mode));
        if (em == 3'h4) begin
            // three edges of the period have already gone by since the last pulse
            rf_gap(gaps[sl] - 16'h0003);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        rms_host_model_i.send_byte({1'b0, a, 1'b0});
        rms_host_model_i.send_byte(d);
    endtask

    // read waits for its reply before anything else goes out
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        int n;
        exp_q.push_back(e);
        rms_host_model_i.send_byte({1'b1, a, 1'b0});
        for (n = 0; n < 400 && exp_q.size() != 0; n++) @(negedge clock);
        if (exp_q.size() != 0) chk_v("reply missing", 16'h0000, 16'h0001);
        repeat (16) @(negedge clock);
    endtask

    task automatic pulse(input int k);
        irq_event = 7'(7'h01 << k);
        @(negedge clock);
        irq_event = 7'h00;
    endtask

    // --------------------------------------------------------------------
    // reply watcher: every byte the host gets must have been noted
    // --------------------------------------------------------------------
    always @(posedge clock) begin
        if (got_valid === 1'b1) begin
            if (exp_q.size() == 0) chk_v("unexpected reply", 16'hFFFF, {8'h00, got_byte});
            else chk_v("reply byte", {8'h00, exp_q.pop_front()}, {8'h00, got_byte});
        end
    end

    // watchdog sized well above the expected run of a few thousand cycles
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end

    // --------------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------------
    initial begin
        int k;
        logic [7:0] d;
        do_reset(1'b1, 1'b1, 2'(xs()));
        do_reset(1'b0, 1'b0, 2'(xs()));
        pulse(0);
        // standard mode keeps the emulated link silent: no reply may come back
        rms_host_model_i.send_byte({1'b1, 6'h02, 1'b0});
        repeat (200) @(negedge clock);
        chk_v("std link idle", 16'h0001, 16'(txd));
        chk_v("std pin idle", 16'h0001, 16'(irq_oe_n));
        for (int s = 0; s < 4; s++) do_reset(1'b0, 1'b1, 2'(s));
        do_reset(1'b1, 1'b0, 2'(xs()));
        k = int'(xs() % 7);
        wr(6'h02, 8'hFF);
        chk_v("irq idle", 16'h0001, 16'(irq_pin));
        pulse(k);
        repeat (2) @(negedge clock);
        chk_v("irq pending", 16'h0000, 16'(irq_pin));
        repeat (20) @(negedge clock);
        chk_v("irq held", 16'h0000, 16'(irq_pin));
        wr(6'h04, 8'(8'h01 << k));
        repeat (2) @(negedge clock);
        chk_v("irq cleared", 16'h0001, 16'(irq_pin));
        rd(6'h02, 8'hFF);
        wr(6'h1F, 8'(xs()));
        rd(6'h1F, 8'h00);
        d = 8'(xs());
        wr(6'h10, d);
        rd(6'h10, d);
        chk_v("rf bytes vary", 16'h0001, 16'(rf_diff > 1));
        tally_and_finish();
    end
endmodule
`default_nettype wire
